// ---- rtl/mbtcp_handler.sv ----
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mbtcp_handler (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  output logic rx_ready_out,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  input wire logic contact_run_in,
  input wire logic [31:0] ip_boot_in,
  input wire logic [15:0] nv_temp0_in,
  input wire logic [15:0] nv_temp1_in,
  output logic run_out,
  output logic [31:0] active_ip_out,
  output logic panel_restart_out,
  output logic nvm_wr_out,
  output logic nvm_sel_out,
  output logic [15:0] nvm_data_out
);
  mbtcp_pkg::mbtcp_state_e state_ff;
  mbtcp_pkg::mbtcp_state_e nxt_state;
  logic [7:0] rx_buf_ff [0:255];
  logic [15:0] tab_ff [0:63];
  logic [8:0] rx_cnt_ff;
  logic ovf_ff;
  logic rx_rdy_ff;
  logic boot_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] ip_pend_ff;
  logic [31:0] ip_act_ff;
  logic [31:0] mask_ff;
  logic [31:0] gw_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic restart_ff;
  logic run_ff;
  logic [7:0] exc_ff;
  logic [2:0] wr_cnt_ff;
  logic [8:0] tx_idx_ff;
  logic [7:0] tx_data_ff;
  logic tx_valid_ff;
  logic tx_last_ff;
  logic [7:0] fc;
  logic [15:0] start;
  logic [15:0] qty;
  logic [5:0] sidx;
  logic hdr_ok;
  logic [7:0] exc;
  logic [8:0] rsp_len;
  logic [7:0] rsp_byte;
  logic [5:0] wr_idx;
  logic [15:0] wr_word;
  logic wr_last;
  logic [7:0] wb;
  logic [31:0] rd_val;
  logic [31:0] wmerge;
  logic av_go;
  logic rx_take;
  logic tx_done;
  mbtcp_nv_if nv_bus ();

  function automatic logic range_ok(input logic [15:0] s, input logic [15:0] q,
                                    input logic [15:0] lo, input logic [15:0] hi);
    logic [16:0] e;
    e = {1'b0, s} + {1'b0, q};
    return (s >= lo) && (e <= ({1'b0, hi} + 17'h0_0001));
  endfunction

  function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  assign rx_take = rx_valid_in && rx_ready_out;
  assign tx_done = tx_valid_ff && tx_ready_in && tx_last_ff;
  assign av_go = !wait_ff && (avs_read_in || avs_write_in);

  // Request decode; unit identifier takes no part
  always_comb
  begin
    fc = rx_buf_ff[7];
    start = {rx_buf_ff[8], rx_buf_ff[9]};
    qty = {rx_buf_ff[10], rx_buf_ff[11]};
    sidx = 6'(start - mbtcp_pkg::TAB_BASE);
    hdr_ok = !ovf_ff && rx_cnt_ff >= mbtcp_pkg::MIN_FRAME
      && rx_buf_ff[2] == 8'h00 && rx_buf_ff[3] == 8'h00 && rx_buf_ff[4] == 8'h00
      && ({1'b0, rx_buf_ff[5]} + mbtcp_pkg::MBAP_PRE) == rx_cnt_ff;
    exc = mbtcp_pkg::EXC_NONE;
    if (fc == mbtcp_pkg::FC_RD)
    begin
      if (qty == 16'h0000 || qty > mbtcp_pkg::RD_MAX)
        exc = mbtcp_pkg::EXC_VAL;
      else if (!range_ok(start, qty, mbtcp_pkg::TAB_BASE, mbtcp_pkg::TAB_LAST))
        exc = mbtcp_pkg::EXC_ADDR;
    end
    else if (fc == mbtcp_pkg::FC_WR1)
    begin
      if (!ctrl_ff[mbtcp_pkg::CTRL_NET])
        exc = mbtcp_pkg::EXC_MODE;
      else if (!range_ok(start, 16'h0001, mbtcp_pkg::WR_FIRST, mbtcp_pkg::WR_LAST))
        exc = mbtcp_pkg::EXC_ADDR;
    end
    else if (fc == mbtcp_pkg::FC_WRN)
    begin
      if (qty == 16'h0000 || qty > mbtcp_pkg::WR_MAX || rx_buf_ff[12] != {qty[6:0], 1'b0}
          || rx_cnt_ff != mbtcp_pkg::WRN_BASE + {qty[7:0], 1'b0})
        exc = mbtcp_pkg::EXC_VAL;
      else if (!ctrl_ff[mbtcp_pkg::CTRL_NET])
        exc = mbtcp_pkg::EXC_MODE;
      else if (!range_ok(start, qty, mbtcp_pkg::WR_FIRST, mbtcp_pkg::WR_LAST))
        exc = mbtcp_pkg::EXC_ADDR;
    end
    else
      exc = mbtcp_pkg::EXC_FUNC;
  end

  // Write loop operand
  always_comb
  begin
    wb = {4'h0, wr_cnt_ff, 1'b0} + mbtcp_pkg::WRN_DATA;
    wr_idx = sidx + {3'h0, wr_cnt_ff};
    if (fc == mbtcp_pkg::FC_WR1)
      wr_word = {rx_buf_ff[10], rx_buf_ff[11]};
    else
      wr_word = {rx_buf_ff[wb], rx_buf_ff[8'(wb + 8'h01)]};
    wr_last = (fc == mbtcp_pkg::FC_WR1) || ({13'h0000, wr_cnt_ff} + 16'h0001 == qty);
  end

  // Response byte at tx_idx_ff; no checksum appended
  always_comb
  begin
    logic [8:0] off;
    off = tx_idx_ff - mbtcp_pkg::RSP_BASE;
    if (exc_ff != mbtcp_pkg::EXC_NONE)
      rsp_len = mbtcp_pkg::RSP_BASE;
    else if (fc == mbtcp_pkg::FC_RD)
      rsp_len = mbtcp_pkg::RSP_BASE + {qty[7:0], 1'b0};
    else
      rsp_len = mbtcp_pkg::RSP_WR;
    case (tx_idx_ff)
      9'h000: rsp_byte = rx_buf_ff[0];
      9'h001: rsp_byte = rx_buf_ff[1];
      9'h002, 9'h003, 9'h004: rsp_byte = 8'h00;
      9'h005: rsp_byte = 8'(rsp_len - mbtcp_pkg::MBAP_PRE);
      9'h006: rsp_byte = rx_buf_ff[6];
      9'h007: rsp_byte = (exc_ff != mbtcp_pkg::EXC_NONE) ? (fc | mbtcp_pkg::FC_EXC) : fc;
      9'h008:
      begin
        if (exc_ff != mbtcp_pkg::EXC_NONE)
          rsp_byte = exc_ff;
        else if (fc == mbtcp_pkg::FC_RD)
          rsp_byte = {qty[6:0], 1'b0};
        else
          rsp_byte = rx_buf_ff[8];
      end
      default:
      begin
        if (fc == mbtcp_pkg::FC_RD)
          rsp_byte = off[0] ? tab_ff[6'(sidx + off[6:1])][7:0]
                            : tab_ff[6'(sidx + off[6:1])][15:8];
        else
          rsp_byte = rx_buf_ff[tx_idx_ff[7:0]];
      end
    endcase
  end

  // Frame sequencing; answers only, never originates
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      mbtcp_pkg::ST_RECV:
        if (rx_take && rx_last_in)
          nxt_state = mbtcp_pkg::ST_CHECK;
      mbtcp_pkg::ST_CHECK:
        if (!hdr_ok)
          nxt_state = mbtcp_pkg::ST_RECV;
        else if (exc == mbtcp_pkg::EXC_NONE && fc != mbtcp_pkg::FC_RD)
          nxt_state = mbtcp_pkg::ST_WRITE;
        else
          nxt_state = mbtcp_pkg::ST_SEND;
      mbtcp_pkg::ST_WRITE:
        if (wr_last)
          nxt_state = mbtcp_pkg::ST_SEND;
      mbtcp_pkg::ST_SEND:
        if (tx_done)
          nxt_state = mbtcp_pkg::ST_RECV;
      default:
        nxt_state = mbtcp_pkg::ST_RECV;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= mbtcp_pkg::ST_RECV;
      rx_rdy_ff <= 1'b1;
      exc_ff <= mbtcp_pkg::EXC_NONE;
      wr_cnt_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      rx_rdy_ff <= (nxt_state == mbtcp_pkg::ST_RECV);
      if (state_ff == mbtcp_pkg::ST_CHECK)
        exc_ff <= exc;
      if (state_ff == mbtcp_pkg::ST_WRITE)
        wr_cnt_ff <= wr_cnt_ff + 3'h1;
      else
        wr_cnt_ff <= 3'h0;
    end
  end

  // Request capture
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_cnt_ff <= 9'h000;
      ovf_ff <= 1'b0;
    end
    else if (state_ff != mbtcp_pkg::ST_RECV)
    begin
      rx_cnt_ff <= 9'h000;
      ovf_ff <= 1'b0;
    end
    else if (rx_take)
    begin
      if (rx_cnt_ff[8])
        ovf_ff <= 1'b1;
      else
        rx_cnt_ff <= rx_cnt_ff + 9'h001;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (state_ff == mbtcp_pkg::ST_RECV && rx_take && !rx_cnt_ff[8])
      rx_buf_ff[rx_cnt_ff[7:0]] <= rx_data_in;
  end

  // Response emitter
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_idx_ff <= 9'h000;
      tx_data_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end
    else if (state_ff != mbtcp_pkg::ST_SEND)
    begin
      tx_idx_ff <= 9'h000;
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end
    else if (tx_done)
    begin
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
    end
    else if (!tx_valid_ff || tx_ready_in)
    begin
      tx_data_ff <= rsp_byte;
      tx_valid_ff <= 1'b1;
      tx_last_ff <= (tx_idx_ff + 9'h001 == rsp_len);
      tx_idx_ff <= tx_idx_ff + 9'h001;
    end
  end

  // Register table: network writes, bus writes, restart load
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < 64; i++)
        tab_ff[i] <= 16'h0000;
    end
    else
    begin
      if (av_go && avs_write_in && avs_address_in[9:8] == mbtcp_pkg::AV_TAB_SEL)
        tab_ff[avs_address_in[7:2]] <= 16'(apply_be({16'h0000, tab_ff[avs_address_in[7:2]]},
                                              avs_writedata_in, avs_byteenable_in));
      if (boot_ff)
      begin
        tab_ff[mbtcp_pkg::IDX_TEMP0] <= nv_temp0_in;
        tab_ff[mbtcp_pkg::IDX_TEMP1] <= nv_temp1_in;
      end
      else if (state_ff == mbtcp_pkg::ST_WRITE)
        tab_ff[wr_idx] <= wr_word;
    end
  end

  // Set temperature changes go to the keeper
  assign nv_bus.boot = boot_ff;
  assign nv_bus.init0 = nv_temp0_in;
  assign nv_bus.init1 = nv_temp1_in;
  assign nv_bus.req = (state_ff == mbtcp_pkg::ST_WRITE)
    && (wr_idx == mbtcp_pkg::IDX_TEMP0 || wr_idx == mbtcp_pkg::IDX_TEMP1);
  assign nv_bus.ch = (wr_idx == mbtcp_pkg::IDX_TEMP1);
  assign nv_bus.val = wr_word;

  mbtcp_nv_keeper u_keeper (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .nv(nv_bus.keeper)
  );

  // Restart capture and address hold
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      boot_ff <= 1'b1;
      ip_act_ff <= mbtcp_pkg::IP_RST;
    end
    else
    begin
      boot_ff <= 1'b0;
      if (boot_ff)
        ip_act_ff <= ip_boot_in;
    end
  end

  // Bus slave: one wait cycle, then answer
  always_comb
  begin
    if (avs_address_in == mbtcp_pkg::AV_CTRL)
      rd_val = ctrl_ff;
    else if (avs_address_in == mbtcp_pkg::AV_STAT)
      rd_val = {29'h0000_0000, ip_pend_ff != ip_act_ff, state_ff != mbtcp_pkg::ST_RECV, run_ff};
    else if (avs_address_in == mbtcp_pkg::AV_IP_PEND)
      rd_val = ip_pend_ff;
    else if (avs_address_in == mbtcp_pkg::AV_IP_ACT)
      rd_val = ip_act_ff;
    else if (avs_address_in == mbtcp_pkg::AV_MASK)
      rd_val = mask_ff;
    else if (avs_address_in == mbtcp_pkg::AV_GW)
      rd_val = gw_ff;
    else if (avs_address_in[9:8] == mbtcp_pkg::AV_TAB_SEL)
      rd_val = {16'h0000, tab_ff[avs_address_in[7:2]]};
    else
      rd_val = 32'h0000_0000;
  end

  assign wmerge = apply_be(rd_val, avs_writedata_in, avs_byteenable_in);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end
    else if (!wait_ff)
      wait_ff <= 1'b1;
    else if (avs_read_in || avs_write_in)
    begin
      wait_ff <= 1'b0;
      rdata_ff <= avs_read_in ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_ff <= mbtcp_pkg::CTRL_RST;
      ip_pend_ff <= mbtcp_pkg::IP_RST;
      mask_ff <= mbtcp_pkg::MASK_RST;
      gw_ff <= mbtcp_pkg::GW_RST;
      restart_ff <= 1'b0;
    end
    else
    begin
      restart_ff <= 1'b0;
      if (av_go && avs_write_in)
      begin
        if (avs_address_in == mbtcp_pkg::AV_CTRL)
          ctrl_ff <= {30'h0000_0000, wmerge[1:0]};
        else if (avs_address_in == mbtcp_pkg::AV_IP_PEND)
          ip_pend_ff <= wmerge;
        else if (avs_address_in == mbtcp_pkg::AV_MASK)
        begin
          mask_ff <= wmerge;
          restart_ff <= (wmerge != mask_ff);
        end
        else if (avs_address_in == mbtcp_pkg::AV_GW)
        begin
          gw_ff <= wmerge;
          restart_ff <= (wmerge != gw_ff);
        end
      end
    end
  end

  // Run source select
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      run_ff <= 1'b0;
    else if (ctrl_ff[mbtcp_pkg::CTRL_CRS])
      run_ff <= contact_run_in;
    else
      run_ff <= tab_ff[mbtcp_pkg::IDX_OPER][0];
  end

  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign rx_ready_out = rx_rdy_ff;
  assign tx_data_out = tx_data_ff;
  assign tx_valid_out = tx_valid_ff;
  assign tx_last_out = tx_last_ff;
  assign run_out = run_ff;
  assign active_ip_out = ip_act_ff;
  assign panel_restart_out = restart_ff;
  assign nvm_wr_out = nv_bus.wr;
  assign nvm_sel_out = nv_bus.sel;
  assign nvm_data_out = nv_bus.data;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_ip_hold: assert property (!boot_ff |=> $stable(ip_act_ff))
    else $error("active address changed without restart");
  a_contact_run: assert property (ctrl_ff[1] |=> run_out == $past(contact_run_in))
    else $error("run does not follow contact input");
  a_panel_restart: assert property (
    av_go && avs_write_in && avs_address_in == 10'h010 && wmerge != mask_ff |=> panel_restart_out)
    else $error("mask change without panel restart");
  a_server_only: assert property (tx_valid_out |-> state_ff == mbtcp_pkg::ST_SEND)
    else $error("transmit outside a response");
  a_tid_echo: assert property (tx_valid_out && tx_idx_ff == 9'h001 |->
    tx_data_out == rx_buf_ff[0])
    else $error("transaction id not echoed");
  a_proto_zero: assert property (tx_valid_out && tx_idx_ff inside {9'h003, 9'h004, 9'h005}
    |-> tx_data_out == 8'h00)
    else $error("protocol id or length high not zero");
  a_len_exact: assert property (tx_valid_out && tx_last_out |-> tx_idx_ff == rsp_len)
    else $error("response length mismatch");
  a_unit_ignored: assert property (state_ff == mbtcp_pkg::ST_CHECK && hdr_ok
    |=> state_ff != mbtcp_pkg::ST_RECV)
    else $error("valid frame dropped");
  a_write_mode: assert property (state_ff == mbtcp_pkg::ST_WRITE |->
    ctrl_ff[0] && exc_ff == 8'h00 && fc != 8'h04)
    else $error("write outside network mode");
  a_write_ack: assert property (state_ff == mbtcp_pkg::ST_WRITE && wr_last
    |=> state_ff == mbtcp_pkg::ST_SEND ##1 tx_valid_out)
    else $error("write not acknowledged");
  a_exc_flag: assert property (tx_valid_out && tx_idx_ff == 9'h008 && exc_ff != 8'h00
    |-> tx_data_out[7])
    else $error("exception flag missing");
  c_read: cover property (state_ff == mbtcp_pkg::ST_CHECK && hdr_ok && fc == 8'h04 && exc == 8'h00);
  c_wr_multi: cover property (state_ff == mbtcp_pkg::ST_WRITE && wr_cnt_ff == 3'h3);
  c_exception: cover property (tx_valid_out && tx_last_out && exc_ff == 8'h01);
endmodule // mbtcp_handler
`default_nettype wire

// ---- rtl/mbtcp_pkg.sv ----
// Function
// - A set temperature written over the network is kept in non-volatile memory for restarts.
// - The non-volatile copy is written only when the new set temperature differs from it.
// - A newly configured network address is used only after the next restart.
// - With contact run/stop selected, run follows the contact input; registers stay reachable.
// - A change of subnet mask or gateway restarts the operator panel.
// - The remote client sends requests and this block only answers them.
// - The two-byte transaction identifier of a request is copied into its response.
// - The two-byte protocol identifier is zero in requests and responses.
// - The length field has a zero upper byte and the count of following bytes below.
// - The unit identifier is echoed but never used to select the device.
// - Function code and data follow the unit identifier in the serial layout.
// - Frames carry no checksum field.
// - Only read input registers, write single register and write multiple registers exist.
// - Reads work in every mode, writes only in network mode.
// - A fully handled write is answered with a positive response.
package mbtcp_pkg;
  localparam logic [9:0] AV_CTRL = 10'h000;
  localparam logic [9:0] AV_STAT = 10'h004;
  localparam logic [9:0] AV_IP_PEND = 10'h008;
  localparam logic [9:0] AV_IP_ACT = 10'h00C;
  localparam logic [9:0] AV_MASK = 10'h010;
  localparam logic [9:0] AV_GW = 10'h014;
  localparam logic [1:0] AV_TAB_SEL = 2'h1;
  localparam int CTRL_NET = 0;
  localparam int CTRL_CRS = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] IP_RST = 32'hC0A6_0028;
  localparam logic [31:0] MASK_RST = 32'hFFFF_FF00;
  localparam logic [31:0] GW_RST = 32'h0000_0000;
  localparam logic [15:0] TAB_BASE = 16'h0030;
  localparam logic [15:0] TAB_LAST = 16'h006F;
  localparam logic [15:0] WR_FIRST = 16'h0040;
  localparam logic [15:0] WR_LAST = 16'h0043;
  localparam logic [5:0] IDX_TEMP0 = 6'h10;
  localparam logic [5:0] IDX_TEMP1 = 6'h11;
  localparam logic [5:0] IDX_OPER = 6'h12;
  localparam logic [7:0] FC_RD = 8'h04;
  localparam logic [7:0] FC_WR1 = 8'h06;
  localparam logic [7:0] FC_WRN = 8'h10;
  localparam logic [7:0] FC_EXC = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VAL = 8'h03;
  localparam logic [7:0] EXC_MODE = 8'h04;
  localparam logic [15:0] RD_MAX = 16'h007D;
  localparam logic [15:0] WR_MAX = 16'h0004;
  localparam logic [8:0] MBAP_PRE = 9'h006;
  localparam logic [8:0] MIN_FRAME = 9'h008;
  localparam logic [8:0] RSP_BASE = 9'h009;
  localparam logic [8:0] RSP_WR = 9'h00C;
  localparam logic [8:0] WRN_BASE = 9'h00D;
  localparam logic [7:0] WRN_DATA = 8'h0D;
  typedef enum logic [1:0] {
    ST_RECV = 2'b00,
    ST_CHECK = 2'b01,
    ST_WRITE = 2'b11,
    ST_SEND = 2'b10
  } mbtcp_state_e;
endpackage

// ---- rtl/mbtcp_nv_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mbtcp_nv_if;
  logic boot;
  logic [15:0] init0;
  logic [15:0] init1;
  logic req;
  logic ch;
  logic [15:0] val;
  logic wr;
  logic sel;
  logic [15:0] data;
  modport handler (output boot, init0, init1, req, ch, val, input wr, sel, data);
  modport keeper (input boot, init0, init1, req, ch, val, output wr, sel, data);
endinterface
`default_nettype wire

// ---- rtl/mbtcp_nv_keeper.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbtcp_nv_keeper (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  mbtcp_nv_if.keeper nv
);
  logic [15:0] copy_ff [0:1];
  logic wr_ff;
  logic sel_ff;
  logic [15:0] data_ff;
  logic differs;

  assign differs = nv.req && (nv.val != copy_ff[nv.ch]);

  // Stored copy mirrors the non-volatile content
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      copy_ff[0] <= 16'h0000;
      copy_ff[1] <= 16'h0000;
    end
    else if (nv.boot)
    begin
      copy_ff[0] <= nv.init0;
      copy_ff[1] <= nv.init1;
    end
    else if (differs)
      copy_ff[nv.ch] <= nv.val;
  end

  // Memory write only on change
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ff <= 1'b0;
      sel_ff <= 1'b0;
      data_ff <= 16'h0000;
    end
    else
    begin
      wr_ff <= differs && !nv.boot;
      if (differs)
      begin
        sel_ff <= nv.ch;
        data_ff <= nv.val;
      end
    end
  end

  assign nv.wr = wr_ff;
  assign nv.sel = sel_ff;
  assign nv.data = data_ff;

  a_nv_on_change: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    differs && !nv.boot |=> wr_ff && data_ff == $past(nv.val) && sel_ff == $past(nv.ch))
    else $error("changed set temperature not stored");
  a_nv_same_skip: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    nv.req && nv.val == copy_ff[nv.ch] |=> !wr_ff)
    else $error("unchanged set temperature rewritten");
  c_nv_write: cover property (@(posedge mclk_in) disable iff (!rst_n_in) wr_ff);
endmodule // mbtcp_nv_keeper
`default_nettype wire

// ---- verif/mbtcp_client.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbtcp_client (
  input wire logic mclk_in,
  input wire logic rx_ready_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_last_out,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  output logic tx_ready_out
);
  typedef logic [7:0] mbtcp_bq_t[$];
  initial
  begin
    rx_data_out = 8'h3C;
    rx_valid_out = 1'b0;
    rx_last_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // Client speaks first, then only collects the answer
  task automatic xfer(input mbtcp_bq_t req, input logic slow, output mbtcp_bq_t rsp,
    output logic hung);
    int n;
    rsp = {};
    hung = 1'b0;
    foreach (req[i])
    begin
      rx_data_out <= req[i];
      rx_valid_out <= 1'b1;
      rx_last_out <= (i == req.size() - 1);
      n = 0;
      do
      begin
        @(posedge mclk_in);
        n++;
      end
      while (rx_ready_in !== 1'b1 && n < 50);
      if (rx_ready_in !== 1'b1)
        hung = 1'b1;
    end
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
    tx_ready_out <= 1'b1;
    n = 0;
    while (n < 400)
    begin
      @(posedge mclk_in);
      n++;
      if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1)
      begin
        rsp.push_back(tx_data_in);
        if (tx_last_in === 1'b1)
          break;
      end
      if (slow)
        tx_ready_out <= ~tx_ready_out;
    end
    tx_ready_out <= 1'b0;
    if (n >= 400)
      hung = 1'b1;
  endtask
endmodule // mbtcp_client
`default_nettype wire

// ---- verif/mbtcp_handler_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbtcp_handler_bench;
  typedef logic [7:0] mbtcp_bq_t[$];
  localparam logic [31:0] IPB = 32'h0A00_0102;
  localparam logic [15:0] T0 = 16'h0111;
  localparam logic [15:0] T1 = 16'h0222;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [9:0] avs_address_in = 10'h000;
  logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out, active_ip_out;
  logic avs_waitrequest_out, rx_valid_in, rx_last_in, rx_ready_out, tx_valid_out, tx_last_out;
  logic tx_ready_in, run_out, panel_restart_out, nvm_wr_out, nvm_sel_out, contact_run_in = 1'b0;
  logic [7:0] rx_data_in, tx_data_out, tid = 8'h00;
  logic [15:0] nvm_data_out;
  int failures = 0, num_checks = 0, nwr = 0, nrs = 0;
  mbtcp_handler i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in),
    .rx_last_in(rx_last_in), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
    .contact_run_in(contact_run_in), .ip_boot_in(IPB), .nv_temp0_in(T0), .nv_temp1_in(T1),
    .run_out(run_out), .active_ip_out(active_ip_out), .panel_restart_out(panel_restart_out),
    .nvm_wr_out(nvm_wr_out), .nvm_sel_out(nvm_sel_out), .nvm_data_out(nvm_data_out));
  mbtcp_client i_cli (.mclk_in(mclk_in), .rx_ready_in(rx_ready_out), .rx_data_out(rx_data_in),
    .rx_valid_out(rx_valid_in), .rx_last_out(rx_last_in), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in));
  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    if (nvm_wr_out === 1'b1)
      nwr++;
    if (panel_restart_out === 1'b1)
      nrs++;
  end
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo();
    failures++;
    end_sim();
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h saw %h", nm, e, g);
    end
  endtask
  task automatic chkq(string nm, mbtcp_bq_t e, mbtcp_bq_t g);
    logic bad;
    num_checks++;
    bad = (e.size() != g.size());
    foreach (e[i])
      if (!bad && e[i] !== g[i])
        bad = 1'b1;
    if (bad)
    begin
      failures++;
      $display("[FAIL] %s exp %p saw %p", nm, e, g);
    end
  endtask
  task automatic av(logic w, logic [9:0] a, logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 20);
    r = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 20)
      tmo();
  endtask
  // No checksum, unit id arbitrary
  function automatic mbtcp_bq_t frm(logic [7:0] fc, mbtcp_bq_t d);
    mbtcp_bq_t q;
    q = {tid, ~tid, 8'h00, 8'h00, 8'h00, 8'(d.size() + 2), 8'hA5, fc};
    return {q, d};
  endfunction
  task automatic txn(string nm, logic [7:0] fc, mbtcp_bq_t d, logic [7:0] rfc, mbtcp_bq_t e);
    mbtcp_bq_t rsp;
    logic hung;
    tid = tid + 8'h11;
    i_cli.xfer(frm(fc, d), tid[0], rsp, hung);
    if (hung)
      tmo();
    chkq(nm, frm(rfc, e), rsp);
  endtask
  task automatic t_read();
    logic [31:0] r;
    av(1'b0, mbtcp_pkg::AV_CTRL, 32'h0000_0000, r);
    chk("ctrl", mbtcp_pkg::CTRL_RST, r);
    av(1'b0, 10'h3F0, 32'h0000_0000, r);
    chk("unmapped", 32'h0000_0000, r);
    txn("rd", mbtcp_pkg::FC_RD, {8'h00, 8'h40, 8'h00, 8'h02}, mbtcp_pkg::FC_RD,
      {8'h04, T0[15:8], T0[7:0], T1[15:8], T1[7:0]});
    $display("t_read done");
  endtask
  task automatic t_exc();
    logic [7:0] fcs[3] = '{8'h03, 8'h01, 8'h05};
    txn("wr_mode", mbtcp_pkg::FC_WR1, {8'h00, 8'h40, 8'h01, 8'h23},
      mbtcp_pkg::FC_WR1 | mbtcp_pkg::FC_EXC, {mbtcp_pkg::EXC_MODE});
    foreach (fcs[i])
      txn("bad_fc", fcs[i], {8'h00, 8'h40, 8'h00, 8'h01},
        fcs[i] | mbtcp_pkg::FC_EXC, {mbtcp_pkg::EXC_FUNC});
    txn("bad_addr", mbtcp_pkg::FC_RD, {8'h00, 8'h70, 8'h00, 8'h01},
      mbtcp_pkg::FC_RD | mbtcp_pkg::FC_EXC, {mbtcp_pkg::EXC_ADDR});
    txn("bad_qty", mbtcp_pkg::FC_RD, {8'h00, 8'h40, 8'h00, 8'h00},
      mbtcp_pkg::FC_RD | mbtcp_pkg::FC_EXC, {mbtcp_pkg::EXC_VAL});
    chk("no_nvm", 32'h0, 32'(nwr));
    $display("t_exc done");
  endtask
  task automatic t_write();
    logic [31:0] r;
    av(1'b1, mbtcp_pkg::AV_CTRL, 32'h0000_0001, r);
    txn("wr1", mbtcp_pkg::FC_WR1, {8'h00, 8'h40, 8'h01, 8'h23},
      mbtcp_pkg::FC_WR1, {8'h00, 8'h40, 8'h01, 8'h23});
    chk("nvm_cnt", 32'h1, 32'(nwr));
    chk("nvm_data", 32'h0000_0123, {16'h0, nvm_data_out});
    txn("wr1_same", mbtcp_pkg::FC_WR1, {8'h00, 8'h40, 8'h01, 8'h23},
      mbtcp_pkg::FC_WR1, {8'h00, 8'h40, 8'h01, 8'h23});
    chk("nvm_same", 32'h1, 32'(nwr));
    txn("wrn", mbtcp_pkg::FC_WRN, {8'h00, 8'h40, 8'h00, 8'h04, 8'h08, 8'h01, 8'h23,
      8'h04, 8'h56, 8'h00, 8'h00, 8'h00, 8'h00},
      mbtcp_pkg::FC_WRN, {8'h00, 8'h40, 8'h00, 8'h04});
    chk("nvm_wrn", 32'h2, 32'(nwr));
    chk("nvm_sel", 32'h1, {31'h0, nvm_sel_out});
    av(1'b0, 10'h144, 32'h0000_0000, r);
    chk("tab41", 32'h0000_0456, r);
    $display("t_write done");
  endtask
  task automatic t_cfg();
    logic [31:0] r;
    av(1'b1, mbtcp_pkg::AV_MASK, 32'hFFFF_0000, r);
    av(1'b1, mbtcp_pkg::AV_GW, 32'h0A00_0001, r);
    av(1'b1, mbtcp_pkg::AV_IP_PEND, 32'h0A00_0909, r);
    av(1'b0, mbtcp_pkg::AV_STAT, 32'h0000_0000, r);
    chk("stat", 32'h0000_0004, r);
    av(1'b0, mbtcp_pkg::AV_IP_ACT, 32'h0000_0000, r);
    chk("ip_act", IPB, r);
    chk("ip_out", IPB, active_ip_out);
    chk("restart", 32'h2, 32'(nrs));
    av(1'b1, mbtcp_pkg::AV_CTRL, 32'h0000_0003, r);
    contact_run_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk("run_on", 32'h1, {31'h0, run_out});
    contact_run_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk("run_off", 32'h0, {31'h0, run_out});
    $display("t_cfg done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    t_read();
    t_exc();
    t_write();
    t_cfg();
    end_sim();
  end
endmodule // mbtcp_handler_bench
`default_nettype wire
